// file: design/ccsp_regs.vh
// Constants for the codec control serial port
`ifndef CCSP_REGS_VH
`define CCSP_REGS_VH
// ----------------------------------------
// Register map and reset values
// ----------------------------------------
`define CCSP_PAGE_CTRL_ADDR 7'h00
`define CCSP_PAGE_CTRL_RESET 8'h00
`define CCSP_REG_RESET 8'h00
`define CCSP_LAST_ADDR 7'h7F
`define CCSP_NUM_PAGES 2
// ----------------------------------------
// Command byte layout
// ----------------------------------------
`define CCSP_CMD_ADDR_MSB 7
`define CCSP_CMD_ADDR_LSB 1
`define CCSP_CMD_DIR_BIT 0
`define CCSP_BYTE_LAST_BIT 4'h7
`define CCSP_BYTE_BITS 4'h8
// ----------------------------------------
// Two-wire slave addressing
// ----------------------------------------
`define CCSP_I2C_FIXED_MSBS 5'h06
`define CCSP_I2C_GENERAL_CALL 7'h00
`endif

// file: design/ccsp_sync.v
// Two-flop synchroniser bank for pins entering the core clock domain
`timescale 1ns/1ps
module ccsp_sync #(
    parameter W = 8,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input wire CLK_IN,
    input wire RST_N_IN,
    input wire [W-1:0] ASYNC_IN,
    output wire [W-1:0] SYNC_OUT
);
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            reg meta_reg;
            reg stable_reg;
            // First stage feeds only the second stage
            always @(posedge CLK_IN) begin
                if (!RST_N_IN) begin
                    meta_reg <= RST_VAL[g];
                    stable_reg <= RST_VAL[g];
                end else begin
                    meta_reg <= ASYNC_IN[g];
                    stable_reg <= meta_reg;
                end
            end
            assign SYNC_OUT[g] = stable_reg;
        end
    endgenerate
endmodule

// file: design/ccsp_control_port.v
// Codec control port: SPI or two-wire slave over a two-page register file
`timescale 1ns/1ps
`include "ccsp_regs.vh"
// Operation
// - Strap high selects SPI, low selects two-wire
// - SPI clock idles low; four pins
// - Clock phase one: drive on first edge
// - Full duplex shifting in and out
// - First byte is command; data only if write
// - Chip select may stay low between transfers
// - Command: seven address bits, then direction bit
// - Direction zero writes second byte to register
// - Direction one returns register on MISO
// - Pages of 128; address zero selects page
// - Two pages, page zero after reset
// - Value one selects page one, zero page zero
// - Continuous write stores successive registers
// - Continuous read returns successive registers
// - Chip select rising ends frame and stream
// - Streaming never crosses a page boundary
// - Two-wire slave, seven-bit address, both speeds
// - Slave address is 00110 plus two straps
// - Chip select low required for SPI access
// - Two-wire write auto-increments without stop
// - Two-wire general call is acknowledged
// - Master acknowledge fetches next register
module ccsp_control_port (
    input wire CLK_IN,
    input wire RST_N_IN,
    input wire SPI_SELECT_IN,
    input wire CHIP_SELECT_N_IN,
    input wire SCLK_IN,
    input wire MOSI_IN,
    input wire ADDR_STRAP_LO_IN,
    input wire ADDR_STRAP_HI_IN,
    input wire SCL_IN,
    input wire SDA_IN,
    output reg MISO_OUT,
    output reg MISO_OE_OUT,
    output reg SDA_OUT,
    output reg SDA_OE_OUT,
    output reg ACTIVE_PAGE_OUT,
    output reg WR_STROBE_OUT,
    output reg WR_PAGE_OUT,
    output reg [6:0] WR_ADDR_OUT,
    output reg [7:0] WR_DATA_OUT
);
    // ----------------------------------------
    // Two-wire slave states
    // ----------------------------------------
    localparam [6:0] I_IDLE = 7'h01;
    localparam [6:0] I_DEVADR = 7'h02;
    localparam [6:0] I_ACK = 7'h04;
    localparam [6:0] I_REGADR = 7'h08;
    localparam [6:0] I_WDATA = 7'h10;
    localparam [6:0] I_RDATA = 7'h20;
    localparam [6:0] I_MACK = 7'h40;

    // ----------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------
    wire [7:0] pins_s;
    wire sel_s = pins_s[0];
    wire cs_n_s = pins_s[1];
    wire sclk_s = pins_s[2];
    wire mosi_s = pins_s[3];
    wire scl_s = pins_s[4];
    wire sda_s = pins_s[5];
    wire strap_lo_s = pins_s[6];
    wire strap_hi_s = pins_s[7];
    reg cs_n_prev_reg;
    reg sclk_prev_reg;
    reg scl_prev_reg;
    reg sda_prev_reg;

    // Idle levels at reset avoid phantom edges on release
    ccsp_sync #(.W(8), .RST_VAL(8'h32)) u_sync (
        .CLK_IN(CLK_IN),
        .RST_N_IN(RST_N_IN),
        .ASYNC_IN({ADDR_STRAP_HI_IN, ADDR_STRAP_LO_IN, SDA_IN, SCL_IN,
            MOSI_IN, SCLK_IN, CHIP_SELECT_N_IN, SPI_SELECT_IN}),
        .SYNC_OUT(pins_s)
    );

    // Edges seen in the same core cycle that the synchronised level moves
    wire cs_fall = cs_n_prev_reg & ~cs_n_s;
    wire sclk_rise = ~sclk_prev_reg & sclk_s;
    wire sclk_fall = sclk_prev_reg & ~sclk_s;
    wire scl_rise = ~scl_prev_reg & scl_s;
    wire scl_fall = scl_prev_reg & ~scl_s;
    wire i2c_start = scl_prev_reg & scl_s & sda_prev_reg & ~sda_s;
    wire i2c_stop = scl_prev_reg & scl_s & ~sda_prev_reg & sda_s;

    // ----------------------------------------
    // Register storage and engine state
    // ----------------------------------------
    reg [7:0] reg_file [0:255];
    reg [7:0] page_reg;
    reg frame_page_reg;
    reg [6:0] ptr_reg;
    reg dir_rd_reg;
    reg cmd_done_reg;
    reg [3:0] cnt_reg;
    reg [7:0] rx_reg;
    reg [7:0] tx_reg;
    reg [6:0] i2c_state_reg;
    reg [6:0] i2c_after_ack_reg;
    reg mack_reg;
    integer i;

    wire [7:0] spi_byte = {rx_reg[6:0], mosi_s};
    wire [6:0] i2c_own_addr = {`CCSP_I2C_FIXED_MSBS, strap_hi_s, strap_lo_s};
    // Pointer holds at the last register so no stream leaves its page
    wire [6:0] ptr_next = (ptr_reg == `CCSP_LAST_ADDR) ? ptr_reg : ptr_reg + 7'h01;

    // Address zero is the page register on every page
    function [7:0] read_reg;
        input pg;
        input [6:0] a;
        begin
            if (a == `CCSP_PAGE_CTRL_ADDR) begin
                read_reg = page_reg;
            end else begin
                read_reg = reg_file[{pg, a}];
            end
        end
    endfunction

    // Two-wire sender needs bit slices, so the lookups are named nets
    wire [7:0] rd_at_ptr = read_reg(frame_page_reg, ptr_reg);
    wire [7:0] rd_at_next = read_reg(frame_page_reg, ptr_next);

    // Store one byte and announce it to the datapath
    task store;
        input pg;
        input [6:0] a;
        input [7:0] d;
        begin
            if (a == `CCSP_PAGE_CTRL_ADDR) begin
                page_reg <= d;
                ACTIVE_PAGE_OUT <= d[0];
            end else begin
                reg_file[{pg, a}] <= d;
            end
            WR_STROBE_OUT <= 1'b1;
            WR_PAGE_OUT <= pg;
            WR_ADDR_OUT <= a;
            WR_DATA_OUT <= d;
        end
    endtask

    // ----------------------------------------
    // Protocol engines
    // ----------------------------------------
    always @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            for (i = 0; i < 256; i = i + 1) begin
                reg_file[i] <= `CCSP_REG_RESET;
            end
            page_reg <= `CCSP_PAGE_CTRL_RESET;
            ACTIVE_PAGE_OUT <= 1'b0;
            frame_page_reg <= 1'b0;
            cs_n_prev_reg <= 1'b1;
            sclk_prev_reg <= 1'b0;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            ptr_reg <= 7'h00;
            dir_rd_reg <= 1'b0;
            cmd_done_reg <= 1'b0;
            cnt_reg <= 4'h0;
            rx_reg <= 8'h00;
            tx_reg <= 8'h00;
            i2c_state_reg <= I_IDLE;
            i2c_after_ack_reg <= I_IDLE;
            mack_reg <= 1'b0;
            MISO_OUT <= 1'b0;
            MISO_OE_OUT <= 1'b0;
            SDA_OUT <= 1'b0;
            SDA_OE_OUT <= 1'b0;
            WR_STROBE_OUT <= 1'b0;
            WR_PAGE_OUT <= 1'b0;
            WR_ADDR_OUT <= 7'h00;
            WR_DATA_OUT <= 8'h00;
        end else begin
            cs_n_prev_reg <= cs_n_s;
            sclk_prev_reg <= sclk_s;
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
            WR_STROBE_OUT <= 1'b0;
            SDA_OUT <= 1'b0;
            if (sel_s) begin
                // SPI: two-wire side held idle and released
                i2c_state_reg <= I_IDLE;
                SDA_OE_OUT <= 1'b0;
                if (cs_n_s) begin
                    // Frame over: stream stops, next needs a command byte
                    MISO_OE_OUT <= 1'b0;
                    MISO_OUT <= 1'b0;
                    cnt_reg <= 4'h0;
                    cmd_done_reg <= 1'b0;
                end else if (cs_fall) begin
                    // Page is frozen for the whole frame
                    MISO_OE_OUT <= 1'b1;
                    frame_page_reg <= page_reg[0];
                    cnt_reg <= 4'h0;
                    cmd_done_reg <= 1'b0;
                    tx_reg <= 8'h00;
                end else if (sclk_rise) begin
                    // Launch on rising edge, master samples on falling
                    MISO_OE_OUT <= 1'b1;
                    MISO_OUT <= tx_reg[7];
                    tx_reg <= {tx_reg[6:0], 1'b0};
                end else if (sclk_fall) begin
                    // Sample on falling edge with clock idling low
                    rx_reg <= spi_byte;
                    if (cnt_reg == `CCSP_BYTE_LAST_BIT) begin
                        cnt_reg <= 4'h0;
                        if (!cmd_done_reg) begin
                            cmd_done_reg <= 1'b1;
                            ptr_reg <= spi_byte[`CCSP_CMD_ADDR_MSB:`CCSP_CMD_ADDR_LSB];
                            dir_rd_reg <= spi_byte[`CCSP_CMD_DIR_BIT];
                            if (spi_byte[`CCSP_CMD_DIR_BIT]) begin
                                tx_reg <= read_reg(frame_page_reg,
                                    spi_byte[`CCSP_CMD_ADDR_MSB:`CCSP_CMD_ADDR_LSB]);
                            end
                        end else if (!dir_rd_reg) begin
                            store(frame_page_reg, ptr_reg, spi_byte);
                            ptr_reg <= ptr_next;
                        end else begin
                            tx_reg <= read_reg(frame_page_reg, ptr_next);
                            ptr_reg <= ptr_next;
                        end
                    end else begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end
            end else begin
                // Two-wire slave; SPI output released
                MISO_OE_OUT <= 1'b0;
                MISO_OUT <= 1'b0;
                if (i2c_stop) begin
                    i2c_state_reg <= I_IDLE;
                    SDA_OE_OUT <= 1'b0;
                end else if (i2c_start) begin
                    // Start or repeated start; page frozen from here
                    i2c_state_reg <= I_DEVADR;
                    frame_page_reg <= page_reg[0];
                    cnt_reg <= 4'h0;
                    SDA_OE_OUT <= 1'b0;
                end else if (scl_rise) begin
                    // Sample data and master acknowledge while clock high
                    if (i2c_state_reg == I_MACK) begin
                        mack_reg <= ~sda_s;
                    end else begin
                        rx_reg <= {rx_reg[6:0], sda_s};
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end else if (scl_fall) begin
                    case (i2c_state_reg)
                        I_DEVADR, I_REGADR, I_WDATA: begin
                            if (cnt_reg == `CCSP_BYTE_BITS) begin
                                cnt_reg <= 4'h0;
                                SDA_OE_OUT <= 1'b1;
                                i2c_state_reg <= I_ACK;
                                i2c_after_ack_reg <= I_WDATA;
                                if (i2c_state_reg == I_DEVADR) begin
                                    dir_rd_reg <= rx_reg[0];
                                    i2c_after_ack_reg <= rx_reg[0] ? I_RDATA : I_REGADR;
                                    // General call is write-only
                                    if (!((rx_reg[7:1] == i2c_own_addr) ||
                                        (rx_reg[7:1] == `CCSP_I2C_GENERAL_CALL &&
                                        !rx_reg[0]))) begin
                                        SDA_OE_OUT <= 1'b0;
                                        i2c_state_reg <= I_IDLE;
                                    end
                                end else if (i2c_state_reg == I_REGADR) begin
                                    ptr_reg <= rx_reg[6:0];
                                end else begin
                                    store(frame_page_reg, ptr_reg, rx_reg);
                                    ptr_reg <= ptr_next;
                                end
                            end
                        end
                        I_ACK: begin
                            cnt_reg <= 4'h0;
                            i2c_state_reg <= i2c_after_ack_reg;
                            if (i2c_after_ack_reg == I_RDATA) begin
                                SDA_OE_OUT <= ~rd_at_ptr[7];
                                tx_reg <= {rd_at_ptr[6:0], 1'b0};
                            end else begin
                                SDA_OE_OUT <= 1'b0;
                            end
                        end
                        I_RDATA: begin
                            // Open drain: a zero bit pulls the line low
                            if (cnt_reg == `CCSP_BYTE_BITS) begin
                                cnt_reg <= 4'h0;
                                SDA_OE_OUT <= 1'b0;
                                i2c_state_reg <= I_MACK;
                            end else begin
                                SDA_OE_OUT <= ~tx_reg[7];
                                tx_reg <= {tx_reg[6:0], 1'b0};
                            end
                        end
                        I_MACK: begin
                            if (mack_reg) begin
                                i2c_state_reg <= I_RDATA;
                                SDA_OE_OUT <= ~rd_at_next[7];
                                tx_reg <= {rd_at_next[6:0], 1'b0};
                                ptr_reg <= ptr_next;
                            end else begin
                                i2c_state_reg <= I_IDLE;
                            end
                        end
                        default: begin
                            SDA_OE_OUT <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end
endmodule

// file: bench/ccsp_control_port_sva.sv
// Assertion checker bound to the codec control port
`timescale 1ns/1ps
module ccsp_control_port_sva (
    input wire CLK_IN,
    input wire RST_N_IN,
    input wire SPI_SELECT_IN,
    input wire CHIP_SELECT_N_IN,
    input wire SCLK_IN,
    input wire MOSI_IN,
    input wire ADDR_STRAP_LO_IN,
    input wire ADDR_STRAP_HI_IN,
    input wire SCL_IN,
    input wire SDA_IN,
    input wire MISO_OUT,
    input wire MISO_OE_OUT,
    input wire SDA_OUT,
    input wire SDA_OE_OUT,
    input wire ACTIVE_PAGE_OUT,
    input wire WR_STROBE_OUT,
    input wire WR_PAGE_OUT,
    input wire [6:0] WR_ADDR_OUT,
    input wire [7:0] WR_DATA_OUT
);
    // ----------------------------------------
    // Port relations
    // ----------------------------------------
    default clocking dclk @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // One pulse per stored byte
    AST_STROBE_PULSE: assert property (WR_STROBE_OUT |=> !WR_STROBE_OUT)
        else $error("store strobe wider than one cycle");
    AST_STORE_UPDATES: assert property ($changed(WR_DATA_OUT) |-> WR_STROBE_OUT)
        else $error("store data moved without a strobe");
    AST_STORE_NEEDS_CS: assert property (WR_STROBE_OUT && SPI_SELECT_IN |-> !CHIP_SELECT_N_IN)
        else $error("store while chip select high");
    // Sync and register delay is three cycles, so eight idle cycles is ample
    AST_OE_IDLE: assert property (CHIP_SELECT_N_IN [*8] |-> !MISO_OE_OUT)
        else $error("data out enabled outside a frame");
    AST_OE_SPI_ONLY: assert property (MISO_OE_OUT |-> SPI_SELECT_IN)
        else $error("data out enabled in two-wire mode");
    AST_SDA_QUIET_SPI: assert property (SDA_OE_OUT |-> !SPI_SELECT_IN)
        else $error("two-wire data pulled in SPI mode");
    AST_SDA_OPEN_DRAIN: assert property (!SDA_OUT)
        else $error("two-wire data driven high");
    AST_PAGE_FROM_STORE: assert property ($changed(ACTIVE_PAGE_OUT) |->
        WR_ADDR_OUT == 7'h00 && WR_DATA_OUT[0] == ACTIVE_PAGE_OUT)
        else $error("page moved without a page register store");
    AST_STORE_PAGE: assert property (WR_STROBE_OUT && WR_ADDR_OUT != 7'h00 |->
        WR_PAGE_OUT == ACTIVE_PAGE_OUT)
        else $error("store went to the inactive page");
    // Read bit must hold past the sampling edge
    AST_MISO_HOLD: assert property ($fell(SCLK_IN) && !CHIP_SELECT_N_IN |=>
        $stable(MISO_OUT) [*4])
        else $error("read bit moved near the falling clock");
endmodule
bind ccsp_control_port ccsp_control_port_sva chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
    .SPI_SELECT_IN(SPI_SELECT_IN), .CHIP_SELECT_N_IN(CHIP_SELECT_N_IN), .SCLK_IN(SCLK_IN),
    .MOSI_IN(MOSI_IN), .ADDR_STRAP_LO_IN(ADDR_STRAP_LO_IN), .ADDR_STRAP_HI_IN(ADDR_STRAP_HI_IN),
    .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .MISO_OUT(MISO_OUT), .MISO_OE_OUT(MISO_OE_OUT),
    .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .ACTIVE_PAGE_OUT(ACTIVE_PAGE_OUT),
    .WR_STROBE_OUT(WR_STROBE_OUT), .WR_PAGE_OUT(WR_PAGE_OUT), .WR_ADDR_OUT(WR_ADDR_OUT),
    .WR_DATA_OUT(WR_DATA_OUT));

// file: bench/ccsp_host_mdl.sv
// Host master model: SPI mode 1 (drive on rising, sample on falling), two-wire writes and reads
`timescale 1ns/1ps
module ccsp_host_mdl (
    input wire logic miso_in,
    input wire logic sda_oe_in,
    output logic cs_n_out,
    output logic sclk_out,
    output logic mosi_out,
    output logic scl_out,
    output logic sda_out
);
    logic [7:0] tx [0:7];
    logic [7:0] rx [0:7];
    // ----------------------------------------
    // Idle levels
    // ----------------------------------------
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        mosi_out = 1'b0;
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // Drive on rising edge, sample on falling, MSB first
    task automatic spi_byte(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            sclk_out = 1'b1;
            mosi_out = d[i];
            #62.5;
            sclk_out = 1'b0;
            q[i] = miso_in;
            #62.5;
        end
    endtask
    // Bare clock pulses, used for partial bytes and for noise with select high
    task automatic pulses(input int n);
        for (int i = 0; i < n; i++) begin
            sclk_out = 1'b1;
            #62.5;
            sclk_out = 1'b0;
            #62.5;
        end
    endtask
    // Select stays low over all bytes of one frame
    task automatic spi_frame(input logic [7:0] cmd, input int n, input int tail);
        logic [7:0] q;
        cs_n_out = 1'b0;
        #100;
        spi_byte(cmd, q);
        for (int k = 0; k < n; k++) spi_byte(tx[k], rx[k]);
        pulses(tail);
        #50;
        cs_n_out = 1'b1;
        mosi_out = ~mosi_out; // Released line does not keep its value
        #200;
    endtask
    // One two-wire bit; a counts the slave pulling low
    task automatic i2c_bit(input logic b, output logic a);
        sda_out = b;
        #300;
        scl_out = 1'b1;
        a = sda_oe_in;
        #600;
        scl_out = 1'b0;
        #300;
    endtask
    task automatic i2c_wr(input logic [6:0] dev, input logic [6:0] ra, input logic [7:0] d,
        output int acks);
        logic [7:0] by [0:2];
        logic a;
        by[0] = {dev, 1'b0};
        by[1] = {1'b0, ra};
        by[2] = d;
        acks = 0;
        sda_out = 1'b0;
        #600;
        scl_out = 1'b0;
        for (int k = 0; k < 3; k++) begin
            for (int i = 7; i >= 0; i--) i2c_bit(by[k][i], a);
            i2c_bit(1'b1, a);
            acks += a;
        end
        sda_out = 1'b0;
        #300;
        scl_out = 1'b1;
        #600;
        sda_out = 1'b1;
        #600;
    endtask
    // Pointer set by a write, repeated start, then n bytes; the last is not acknowledged
    task automatic i2c_rd(input logic [6:0] dev, input logic [6:0] ra, input int n);
        logic [7:0] by [0:2];
        logic a;
        by[0] = {dev, 1'b0};
        by[1] = {1'b0, ra};
        by[2] = {dev, 1'b1};
        sda_out = 1'b0;
        #600;
        scl_out = 1'b0;
        for (int k = 0; k < 3; k++) begin
            if (k == 2) begin
                sda_out = 1'b1;
                #300;
                scl_out = 1'b1;
                #600;
                sda_out = 1'b0;
                #600;
                scl_out = 1'b0;
            end
            for (int i = 7; i >= 0; i--) i2c_bit(by[k][i], a);
            i2c_bit(1'b1, a);
        end
        for (int k = 0; k < n; k++) begin
            for (int i = 7; i >= 0; i--) begin
                i2c_bit(1'b1, a);
                rx[k][i] = ~a; // Slave pulling low reads as zero
            end
            i2c_bit(k == n - 1, a);
        end
        sda_out = 1'b0;
        #300;
        scl_out = 1'b1;
        #600;
        sda_out = 1'b1;
        #600;
    endtask
endmodule

// file: bench/tb.sv
// Self-checking bench for the codec control port
`timescale 1ns/1ps
module tb;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic spi_select_in = 1'b1;
    wire cs_n, sclk, mosi, scl, sda_m;
    wire miso, miso_oe, sda_o, sda_oe, page, wr_stb, wr_page;
    wire [6:0] wr_addr;
    wire [7:0] wr_data;
    int bad_count = 0;
    int checks_done = 0;
    int stb_cnt = 0;
    int cycles = 0;
    int acks;
    always #2.5 clk_in = ~clk_in;
    ccsp_host_mdl mdl (.miso_in(miso), .sda_oe_in(sda_oe), .cs_n_out(cs_n), .sclk_out(sclk),
        .mosi_out(mosi), .scl_out(scl), .sda_out(sda_m));
    // Open-drain wire level seen by the slave
    ccsp_control_port dut (.CLK_IN(clk_in), .RST_N_IN(rst_n_in), .SPI_SELECT_IN(spi_select_in),
        .CHIP_SELECT_N_IN(cs_n), .SCLK_IN(sclk), .MOSI_IN(mosi), .ADDR_STRAP_LO_IN(1'b0),
        .ADDR_STRAP_HI_IN(1'b1), .SCL_IN(scl), .SDA_IN(sda_m & ~sda_oe), .MISO_OUT(miso),
        .MISO_OE_OUT(miso_oe), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .ACTIVE_PAGE_OUT(page),
        .WR_STROBE_OUT(wr_stb), .WR_PAGE_OUT(wr_page), .WR_ADDR_OUT(wr_addr),
        .WR_DATA_OUT(wr_data));
    // Store counter and hang limit
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (wr_stb === 1'b1) stb_cnt <= stb_cnt + 1;
        if (cycles == 80000) begin
            bad_count++;
            final_report();
        end
    end
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        mdl.tx[0] = d;
        mdl.spi_frame({a, 1'b0}, 1, 0);
        #6250;
    endtask
    task automatic rd(input logic [6:0] a, input int n);
        mdl.spi_frame({a, 1'b1}, n, 0);
    endtask
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (6) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
        check({7'h00, page}, 8'h00);
        // Offset keeps every SPI edge clear of a core clock edge
        #1.25;
        rd(7'h00, 1);
        check(mdl.rx[0], 8'h00);
        wr(7'h05, 8'hA5);
        check({1'b0, wr_addr}, 8'h05);
        check(wr_data, 8'hA5);
        rd(7'h05, 2);
        check(mdl.rx[0], 8'hA5);
        check(8'(stb_cnt), 8'h01);
        // Stream to the page end; the pointer must not leave the page
        mdl.tx[0] = 8'h11;
        mdl.tx[1] = 8'h22;
        mdl.tx[2] = 8'h33;
        mdl.tx[3] = 8'h44;
        mdl.spi_frame({7'h7D, 1'b0}, 4, 0);
        check(8'(stb_cnt), 8'h05);
        check({1'b0, wr_addr}, 8'h7F);
        rd(7'h7D, 2);
        check(mdl.rx[0], 8'h11);
        check(mdl.rx[1], 8'h22);
        // Page switch and page-private storage
        wr(7'h00, 8'h01);
        check({7'h00, page}, 8'h01);
        rd(7'h00, 1);
        check(mdl.rx[0], 8'h01);
        wr(7'h05, 8'h3C);
        check({7'h00, wr_page}, 8'h01);
        rd(7'h05, 1);
        check(mdl.rx[0], 8'h3C);
        wr(7'h00, 8'h00);
        rd(7'h05, 1);
        check(mdl.rx[0], 8'hA5);
        // Clock noise with select high and a cut-off byte store nothing
        mdl.pulses(16);
        mdl.spi_frame({7'h06, 1'b0}, 0, 5);
        check(8'(stb_cnt), 8'h08);
        rd(7'h06, 1);
        check(mdl.rx[0], 8'h00);
        // Two-wire mode; strap changes only while the bus is idle
        @(negedge clk_in);
        spi_select_in = 1'b0;
        repeat (8) @(negedge clk_in);
        mdl.i2c_wr(7'h1A, 7'h09, 8'h5A, acks);
        check(8'(acks), 8'h03);
        check({1'b0, wr_addr}, 8'h09);
        check(wr_data, 8'h5A);
        mdl.i2c_wr(7'h1B, 7'h09, 8'h77, acks);
        check(8'(acks), 8'h00);
        mdl.i2c_wr(7'h00, 7'h0A, 8'hC3, acks);
        check(8'(acks), 8'h03);
        check(wr_data, 8'hC3);
        // Read back both stored bytes, the second fetched by the master acknowledge
        mdl.i2c_rd(7'h1A, 7'h09, 2);
        check(mdl.rx[0], 8'h5A);
        check(mdl.rx[1], 8'hC3);
        check(8'(stb_cnt), 8'h0A);
        final_report();
    end
endmodule
